// [prc_apb_slave.sv]
// APB slave decode for the peripheral reset control registers
`timescale 1ns/1ns
`default_nettype none

module prc_apb_slave
(
    input  wire logic        psel,      // Slave select
    input  wire logic        penable,   // Access phase
    input  wire logic        pwrite,    // Write direction
    input  wire logic [11:0] paddr,     // Byte address
    output logic             wr_b,      // Write strobe, second register
    output logic             wr_c,      // Write strobe, third register
    output logic             sel_b,     // Address hits second register
    output logic             sel_c,     // Address hits third register
    output logic             pslverr    // Unmapped address, flagged in setup
);
    import prc_pkg::*;

    wire access_w;
    wire setup_w;
    wire mapped_w;

    assign access_w = psel & penable;
    assign setup_w  = psel & ~penable;
    assign sel_b    = (paddr == PRC_ADDR_CTRL_B);
    assign sel_c    = (paddr == PRC_ADDR_CTRL_C);
    assign mapped_w = sel_b | sel_c;
    assign wr_b     = access_w & pwrite & sel_b;
    assign wr_c     = access_w & pwrite & sel_c;
    // Flagged in setup so the top can register it for the access phase
    assign pslverr  = setup_w & ~mapped_w;
endmodule

`default_nettype wire

// [prc_periph_model.sv]
// Behavioural model of the peripheral controllers fed by the reset lines
`timescale 1ns/1ns
`default_nettype none

module prc_periph_model
#(
    parameter int W = 35
)
(
    input  wire logic         pclk,     // Bus clock
    input  wire logic [W-1:0] rst_in,   // Reset lines, active high
    output logic      [W-1:0] alive     // Controller out of reset
);
    genvar i;
    for (i = 0; i < W; i++)
    begin : g_ctrl
        // Held in reset at once, resumes only after the line is released
        always_ff @(posedge pclk or posedge rst_in[i])
        begin
            if (rst_in[i])
                alive[i] <= 1'b0;
            else
                alive[i] <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// [prc_pkg.sv]
// Package of offsets, field positions and reset values for the peripheral reset control block
// Overview of operation
// (RQ1) Writing 1 to an implemented bit asserts that peripheral's asynchronous reset.
// (RQ2) Bits never self-clear; software writes 0 to release the peripheral.
// (RQ3) Second reset register at offset 0x0c, read/write, resets to zero.
// (RQ4) Third reset register at offset 0x10, read/write, resets to zero.
// (RQ5) Second register bits 16, 17, 18 reset serial ports 0, 1, 2.
// (RQ6) Second register bits 12 to 15 reset SPI controllers 0 to 3.
// (RQ7) Second register bits 8 and 9 reset I2C controllers 0 and 1.
// (RQ8) Second register bits 2 to 5 reset timers 0 to 3.
// (RQ9) Second register bit 1 resets the GPIO controller.
// (RQ10) Second register bits 20 and 21 reset PWM lower and upper groups.
// (RQ11) Second register bits 24 and 25 reset CAN controllers 0 and 1.
// (RQ12) Second register bits 27, 28, 29 reset USB device, ADC, I2S.
// (RQ13) Second register bits 22 and 23 reset comparator and PS/2 controllers.
// (RQ14) Third register bits 0, 1, 2 reset smart-card controllers 0, 1, 2.
// (RQ15) Reserved bits read as zero and ignore writes.
`default_nettype none

package prc_pkg;
    localparam logic [11:0] PRC_ADDR_CTRL_B  = 12'h00c;
    localparam logic [11:0] PRC_ADDR_CTRL_C  = 12'h010;
    localparam logic [31:0] PRC_RESET_VALUE  = 32'h0000_0000;
    // Implemented bits of each register
    localparam logic [31:0] PRC_MASK_CTRL_B  = 32'h3bf7_f33e;
    localparam logic [31:0] PRC_MASK_CTRL_C  = 32'h0000_0007;
    // Field positions, second register
    localparam int PRC_GPIO_BIT     = 1;
    localparam int PRC_TIMER0_BIT   = 2;
    localparam int PRC_I2C0_BIT     = 8;
    localparam int PRC_SPI0_BIT     = 12;
    localparam int PRC_SERIAL0_BIT  = 16;
    localparam int PRC_PWM_LO_BIT   = 20;
    localparam int PRC_PWM_HI_BIT   = 21;
    localparam int PRC_CMP_BIT      = 22;
    localparam int PRC_KBD_BIT      = 23;
    localparam int PRC_CAN0_BIT     = 24;
    localparam int PRC_USBD_BIT     = 27;
    localparam int PRC_ADC_BIT      = 28;
    localparam int PRC_I2S_BIT      = 29;
    // Field positions, third register
    localparam int PRC_SC0_BIT      = 0;
endpackage

`default_nettype wire

// [prc_reset_reg.sv]
// One peripheral reset control register with masked reserved bits
`timescale 1ns/1ns
`default_nettype none

module prc_reset_reg
#(
    parameter logic [31:0] IMPL_MASK = 32'h0000_0000
)
(
    input  wire logic        pclk,      // Bus clock
    input  wire logic        presetn,   // Async reset, active low
    input  wire logic        wr_en,     // Write strobe
    input  wire logic [31:0] wdata,     // Write data
    output logic      [31:0] value_q    // Stored value
);
    import prc_pkg::*;

    logic [31:0] value_d;

    // Reserved bits are forced low, so they read zero and ignore writes
    assign value_d = wr_en ? (wdata & IMPL_MASK) : value_q; // RQ15 RQ2

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value_q <= PRC_RESET_VALUE;
        else
            value_q <= value_d; // RQ1
    end
endmodule

`default_nettype wire

// [prc_top.sv]
// Peripheral reset control: two APB registers driving peripheral reset lines
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module prc_top
(
    input  wire logic        pclk,                       // APB clock, 50 MHz
    input  wire logic        presetn,                    // Async reset, active low
    input  wire logic        psel,                       // APB select
    input  wire logic        penable,                    // APB enable
    input  wire logic        pwrite,                     // APB direction
    input  wire logic [11:0] paddr,                      // APB byte address
    input  wire logic [31:0] pwdata,                     // APB write data
    output logic      [31:0] prdata,                     // APB read data
    output logic             pready,                     // APB ready
    output logic             pslverr,                    // APB error
    output logic      [2:0]  serial_port_reset,          // Serial ports 0..2
    output logic      [3:0]  spi_ctrl_reset,             // SPI 0..3
    output logic      [1:0]  i2c_ctrl_reset,             // I2C 0..1
    output logic      [3:0]  timer_reset,                // Timers 0..3
    output logic             gpio_reset,                 // GPIO controller
    output logic             pwm_lower_group_reset,      // PWM channels 0..3
    output logic             pwm_upper_group_reset,      // PWM channels 4..7
    output logic      [1:0]  can_ctrl_reset,             // CAN 0..1
    output logic             usb_device_reset,           // USB device
    output logic             adc_reset,                  // ADC
    output logic             i2s_reset,                  // I2S
    output logic             comparator_reset,           // Analog comparator
    output logic             keyboard_port_reset,        // PS/2
    output logic      [2:0]  smartcard_reset             // Smart-card 0..2
);
    import prc_pkg::*;

    logic [31:0] peripheral_reset_ctrl_b;
    logic [31:0] peripheral_reset_ctrl_c;
    logic        wr_b;
    logic        wr_c;
    logic        sel_b;
    logic        sel_c;
    logic        err_w;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    wire         setup_w;
    wire  [31:0] rd_mux_w;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    prc_apb_slave u_slave
    (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .wr_b    (wr_b),
        .wr_c    (wr_c),
        .sel_b   (sel_b),
        .sel_c   (sel_c),
        .pslverr (err_w)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    prc_reset_reg #(.IMPL_MASK(PRC_MASK_CTRL_B)) u_reg_b // RQ3
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_b),
        .wdata   (pwdata),
        .value_q (peripheral_reset_ctrl_b)
    );

    prc_reset_reg #(.IMPL_MASK(PRC_MASK_CTRL_C)) u_reg_c // RQ4
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_c),
        .wdata   (pwdata),
        .value_q (peripheral_reset_ctrl_c)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer, registered in the setup cycle so it stands through the access phase

    assign setup_w  = psel & ~penable;
    assign rd_mux_w = sel_b ? peripheral_reset_ctrl_b :
                      sel_c ? peripheral_reset_ctrl_c : PRC_RESET_VALUE;
    assign prdata_d = (setup_w & ~pwrite) ? rd_mux_w : prdata_q;
    assign pready_d = setup_w;

    // Zero wait states: ready rises for the first access cycle and drops after it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= PRC_RESET_VALUE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= err_w;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset line fan-out, each straight from a register bit

    assign serial_port_reset     = peripheral_reset_ctrl_b[PRC_SERIAL0_BIT +: 3]; // RQ5
    assign spi_ctrl_reset        = peripheral_reset_ctrl_b[PRC_SPI0_BIT +: 4];    // RQ6
    assign i2c_ctrl_reset        = peripheral_reset_ctrl_b[PRC_I2C0_BIT +: 2];    // RQ7
    assign timer_reset           = peripheral_reset_ctrl_b[PRC_TIMER0_BIT +: 4];  // RQ8
    assign gpio_reset            = peripheral_reset_ctrl_b[PRC_GPIO_BIT];         // RQ9
    assign pwm_lower_group_reset = peripheral_reset_ctrl_b[PRC_PWM_LO_BIT];       // RQ10
    assign pwm_upper_group_reset = peripheral_reset_ctrl_b[PRC_PWM_HI_BIT];       // RQ10
    assign can_ctrl_reset        = peripheral_reset_ctrl_b[PRC_CAN0_BIT +: 2];    // RQ11
    assign usb_device_reset      = peripheral_reset_ctrl_b[PRC_USBD_BIT];         // RQ12
    assign adc_reset             = peripheral_reset_ctrl_b[PRC_ADC_BIT];          // RQ12
    assign i2s_reset             = peripheral_reset_ctrl_b[PRC_I2S_BIT];          // RQ12
    assign comparator_reset      = peripheral_reset_ctrl_b[PRC_CMP_BIT];          // RQ13
    assign keyboard_port_reset   = peripheral_reset_ctrl_b[PRC_KBD_BIT];          // RQ13
    assign smartcard_reset       = peripheral_reset_ctrl_c[PRC_SC0_BIT +: 3];     // RQ14

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_write_sets;
        @(posedge pclk) disable iff (!presetn)
        (wr_b && pwdata[PRC_GPIO_BIT]) |=> gpio_reset;
    endproperty
    a_write_sets: assert property (p_write_sets) else $error("gpio reset not set"); // RQ1

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!wr_b && timer_reset[0]) |=> timer_reset[0];
    endproperty
    a_hold: assert property (p_hold) else $error("reset bit cleared itself"); // RQ2

    property p_reg_b;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (peripheral_reset_ctrl_b == ($past(pwdata) & PRC_MASK_CTRL_B));
    endproperty
    a_reg_b: assert property (p_reg_b) else $error("second register write wrong"); // RQ3

    property p_reg_c;
        @(posedge pclk) disable iff (!presetn)
        wr_c |=> (smartcard_reset == $past(pwdata[2:0]));
    endproperty
    a_reg_c: assert property (p_reg_c) else $error("third register write wrong"); // RQ4

    property p_serial;
        @(posedge pclk) disable iff (!presetn)
        (wr_b && pwdata[18]) |=> serial_port_reset[2];
    endproperty
    a_serial: assert property (p_serial) else $error("serial port 2 reset wrong"); // RQ5

    property p_spi;
        @(posedge pclk) disable iff (!presetn)
        (wr_b && !pwdata[15]) |=> !spi_ctrl_reset[3];
    endproperty
    a_spi: assert property (p_spi) else $error("spi 3 release wrong"); // RQ6

    property p_can;
        @(posedge pclk) disable iff (!presetn)
        (wr_b && pwdata[25]) |=> can_ctrl_reset[1] ##1 (can_ctrl_reset[1] || $past(wr_b));
    endproperty
    a_can: assert property (p_can) else $error("can 1 reset wrong"); // RQ11

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        (peripheral_reset_ctrl_b & ~PRC_MASK_CTRL_B) == 32'h0000_0000
        && (peripheral_reset_ctrl_c & ~PRC_MASK_CTRL_C) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set"); // RQ15

    property p_ready_rise;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready;
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready missing"); // RQ3

    property p_ready_fall;
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable) |=> !pready;
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready outside access"); // RQ3

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long"); // RQ3

    property p_err_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready"); // RQ3

    property p_err_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !sel_b && !sel_c) |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("error missing"); // RQ3 RQ4

    property p_err_mapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && (sel_b || sel_c)) |=> !pslverr;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("false error"); // RQ3 RQ4

    property p_read_b;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_b) |=> (prdata == $past(peripheral_reset_ctrl_b));
    endproperty
    a_read_b: assert property (p_read_b) else $error("second register read wrong"); // RQ3

    property p_read_c;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_c) |=> (prdata == $past(peripheral_reset_ctrl_c));
    endproperty
    a_read_c: assert property (p_read_c) else $error("third register read wrong"); // RQ4

    property p_read_none;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && !sel_b && !sel_c) |=> (prdata == PRC_RESET_VALUE);
    endproperty
    a_read_none: assert property (p_read_none) else $error("unmapped read not zero"); // RQ15

    property p_stable_b;
        @(posedge pclk) disable iff (!presetn)
        !wr_b |=> $stable(peripheral_reset_ctrl_b);
    endproperty
    a_stable_b: assert property (p_stable_b) else $error("second register moved"); // RQ2

    property p_stable_c;
        @(posedge pclk) disable iff (!presetn)
        !wr_c |=> $stable(peripheral_reset_ctrl_c);
    endproperty
    a_stable_c: assert property (p_stable_c) else $error("third register moved"); // RQ2

    property p_serial_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (serial_port_reset == $past(pwdata[PRC_SERIAL0_BIT +: 3]));
    endproperty
    a_serial_f: assert property (p_serial_f) else $error("serial field wrong"); // RQ5

    property p_spi_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (spi_ctrl_reset == $past(pwdata[PRC_SPI0_BIT +: 4]));
    endproperty
    a_spi_f: assert property (p_spi_f) else $error("spi field wrong"); // RQ6

    property p_i2c_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (i2c_ctrl_reset == $past(pwdata[PRC_I2C0_BIT +: 2]));
    endproperty
    a_i2c_f: assert property (p_i2c_f) else $error("i2c field wrong"); // RQ7

    property p_timer_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (timer_reset == $past(pwdata[PRC_TIMER0_BIT +: 4]));
    endproperty
    a_timer_f: assert property (p_timer_f) else $error("timer field wrong"); // RQ8

    property p_gpio_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (gpio_reset == $past(pwdata[PRC_GPIO_BIT]));
    endproperty
    a_gpio_f: assert property (p_gpio_f) else $error("gpio field wrong"); // RQ9

    property p_gpio_release;
        @(posedge pclk) disable iff (!presetn)
        (wr_b && !pwdata[PRC_GPIO_BIT]) |=> !gpio_reset;
    endproperty
    a_gpio_release: assert property (p_gpio_release) else $error("gpio not released"); // RQ2

    property p_pwm_lo_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (pwm_lower_group_reset == $past(pwdata[PRC_PWM_LO_BIT]));
    endproperty
    a_pwm_lo_f: assert property (p_pwm_lo_f) else $error("pwm lower field wrong"); // RQ10

    property p_pwm_hi_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (pwm_upper_group_reset == $past(pwdata[PRC_PWM_HI_BIT]));
    endproperty
    a_pwm_hi_f: assert property (p_pwm_hi_f) else $error("pwm upper field wrong"); // RQ10

    property p_can_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (can_ctrl_reset == $past(pwdata[PRC_CAN0_BIT +: 2]));
    endproperty
    a_can_f: assert property (p_can_f) else $error("can field wrong"); // RQ11

    property p_usb_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (usb_device_reset == $past(pwdata[PRC_USBD_BIT]));
    endproperty
    a_usb_f: assert property (p_usb_f) else $error("usb field wrong"); // RQ12

    property p_adc_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (adc_reset == $past(pwdata[PRC_ADC_BIT]));
    endproperty
    a_adc_f: assert property (p_adc_f) else $error("adc field wrong"); // RQ12

    property p_i2s_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (i2s_reset == $past(pwdata[PRC_I2S_BIT]));
    endproperty
    a_i2s_f: assert property (p_i2s_f) else $error("i2s field wrong"); // RQ12

    property p_cmp_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (comparator_reset == $past(pwdata[PRC_CMP_BIT]));
    endproperty
    a_cmp_f: assert property (p_cmp_f) else $error("comparator field wrong"); // RQ13

    property p_kbd_f;
        @(posedge pclk) disable iff (!presetn)
        wr_b |=> (keyboard_port_reset == $past(pwdata[PRC_KBD_BIT]));
    endproperty
    a_kbd_f: assert property (p_kbd_f) else $error("keyboard port field wrong"); // RQ13

    property p_sc_f;
        @(posedge pclk) disable iff (!presetn)
        wr_c |=> (smartcard_reset == $past(pwdata[PRC_SC0_BIT +: 3]));
    endproperty
    a_sc_f: assert property (p_sc_f) else $error("smart-card field wrong"); // RQ14

    property p_sc_hold;
        @(posedge pclk) disable iff (!presetn)
        (!wr_c && smartcard_reset[0]) |=> smartcard_reset[0];
    endproperty
    a_sc_hold: assert property (p_sc_hold) else $error("smart-card bit cleared itself"); // RQ2
endmodule

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the peripheral reset control block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    localparam logic [31:0] MASK_B = 32'h3bf7_f33e;
    localparam logic [31:0] MASK_C = 32'h0000_0007;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic        gpio, pwl, pwu, usb, adc, i2s, cmp, kbd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, out_b, e;
    logic [3:0]  spi, tmr;
    logic [2:0]  ser, sc;
    logic [1:0]  i2c, can;
    logic [34:0] alive;
    int          err_count, num_checks, cycles;

    assign out_b = {2'h0, i2s, adc, usb, 1'b0, can, kbd, cmp, pwu, pwl, 1'b0, ser, spi,
                    2'h0, i2c, 2'h0, tmr, gpio, 1'b0};

    prc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_port_reset(ser), .spi_ctrl_reset(spi),
        .i2c_ctrl_reset(i2c), .timer_reset(tmr), .gpio_reset(gpio),
        .pwm_lower_group_reset(pwl), .pwm_upper_group_reset(pwu), .can_ctrl_reset(can),
        .usb_device_reset(usb), .adc_reset(adc), .i2s_reset(i2s), .comparator_reset(cmp),
        .keyboard_port_reset(kbd), .smartcard_reset(sc));

    prc_periph_model #(.W(35)) u_periph (.pclk(pclk), .rst_in({sc, out_b}), .alive(alive));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask

    // One APB transfer; read data and error taken at the edge with pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            summarize();
        end
    end

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {err_count, num_checks, cycles} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0);
        check_word(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check_word(rd, 32'h0);
        // Walking one through both registers, including reserved places
        for (int i = 0; i < 32; i++)
        begin
            e = (32'h1 << i) & MASK_B;
            apb(1'b1, 12'h00c, 32'h1 << i);
            settle();
            check_word(out_b, e);
            check_word(alive[31:0], ~e);
            apb(1'b0, 12'h00c, 32'h0);
            check_word(rd, e);
            check_flag(serr, 1'b0);
            e = (32'h1 << i) & MASK_C;
            apb(1'b1, 12'h010, 32'h1 << i);
            settle();
            check_word({29'h0, sc}, e);
            check_word({29'h0, alive[34:32]}, {29'h0, ~e[2:0]});
            apb(1'b0, 12'h010, 32'h0);
            check_word(rd, e);
        end
        // Bits hold without clearing themselves
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        repeat (50) @(posedge pclk);
        apb(1'b0, 12'h00c, 32'h0);
        check_word(rd, MASK_B);
        check_word(out_b, MASK_B);
        // Unmapped address is refused and leaves the registers alone
        apb(1'b1, 12'h014, 32'h0000_0005);
        check_flag(serr, 1'b1);
        apb(1'b0, 12'h014, 32'h0);
        check_word(rd, 32'h0);
        check_flag(serr, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        check_word(rd, MASK_B);
        apb(1'b0, 12'h010, 32'h0);
        check_word(rd, 32'h0);
        apb(1'b1, 12'h00c, 32'h0);
        settle();
        check_word(alive[31:0], 32'hffff_ffff);
        // System reset in mid-run clears every line
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        apb(1'b1, 12'h010, 32'h7);
        settle();
        check_word({29'h0, sc}, 32'h7);
        check_word(out_b, MASK_B);
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check_word({29'h0, sc}, 32'h0);
        check_word(out_b, 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        check_word(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check_word(rd, 32'h0);
        summarize();
    end
endmodule

`default_nettype wire
